//--- rtl/pmh_manager.sv
// Purpose : Power manager end of the processor power handshake port.
// Assumes : All pins synchronous to clk_in; the processor keeps its four-phase handshakes.
// Notes   : Voltage control is a pair of level outputs toward the regulators.
`timescale 1ns/1ps

// Operation
// - Manager drives presence high; absent manager means presence held low.
// - State commands use processor request and manager acknowledge, double ended.
// - Manager acknowledges to accept the 4-bit state command value.
// - Emulation qualifier: change state but keep regulators unchanged.
// - Previous-state retrieval uses its own request and acknowledge pair.
// - Receive acknowledge marks valid previous-state data on the receive bus.
// - Manager drives flag telling if previous state was entered emulated.
// - After command acknowledge, manager places entered state on receive bus.
// - Emulated command is acknowledged and reported without regulator change.
// - Previous-state request answered with acknowledge and previous state.
// - Hard reset asserts hard and soft resets in the same cycle.
// - Hard reset held at least eight cycles.
// - Soft reset held at least eight cycles past hard reset release.
// - Voltage removed and cache lowered only after acknowledged dormant entry.
// - Soft reset held low the whole time processor voltage is removed.
// - Soft reset held eight more cycles after voltages return.
// - State codes: 1111 turbo down to 0000 off, as encoded.
// - After an emulated command completes, manager issues a soft reset sequence.
module pmh_manager (
    input  wire logic                      clk_in,
    input  wire logic                      srst_in,
    input  wire logic                      state_cmd_req_in,
    input  wire logic [pmh_pkg::STATE_W-1:0] state_cmd_value_in,
    input  wire logic                      state_cmd_emulate_in,
    input  wire logic                      prev_state_req_in,
    input  wire logic                      power_restore_in,
    output logic                           manager_present_out,
    output logic                           state_cmd_ack_out,
    output logic                           prev_state_ack_out,
    output logic [pmh_pkg::STATE_W-1:0]    prev_state_value_out,
    output logic                           prev_state_emulated_out,
    output logic                           hard_reset_n_out,
    output logic                           soft_reset_n_out,
    output logic                           core_power_on_out,
    output logic                           cache_retain_out
);
    import pmh_pkg::*;

    // ****************************************
    // Sequencer state
    // ****************************************
    pmh_rst_state_t        rst_state_ff;
    logic [CNT_W-1:0]      cnt_ff;
    logic [STATE_W-1:0]    cur_state_ff;
    logic                  cur_emul_ff;
    logic                  dormant_pend_ff;
    logic                  running;
    logic                  tx_take;
    logic                  tx_done;
    logic                  cnt_end;

    assign running = (rst_state_ff == RS_RUN);
    assign cnt_end = (cnt_ff == CNT_LAST);
    // A command is taken only while running, on a fresh request.
    assign tx_take = running && state_cmd_req_in && !state_cmd_ack_out;
    // The handshake ends when the request falls under the acknowledge.
    assign tx_done = state_cmd_ack_out && !state_cmd_req_in;

    // Presence is asserted from reset onward.
    always_ff @(posedge clk_in) begin
        manager_present_out <= 1'b1;
    end

    // ****************************************
    // Command handshake
    // ****************************************
    // Acknowledge rises on a taken request and falls after the request does.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_cmd_ack_out <= 1'b0;
        end else if (tx_take) begin
            state_cmd_ack_out <= 1'b1;
        end else if (tx_done) begin
            state_cmd_ack_out <= 1'b0;
        end
    end

    // Entered state and its emulation flag are latched with the acknowledge.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cur_state_ff <= PS_RESET_VALUE;
            cur_emul_ff  <= 1'b0;
        end else if (tx_take) begin
            cur_state_ff <= state_cmd_value_in;
            cur_emul_ff  <= state_cmd_emulate_in;
        end
    end

    // Dormant is any non-emulated command with top bits 01, as in nap; it arms the power-down.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dormant_pend_ff <= 1'b0;
        end else if (tx_take) begin
            dormant_pend_ff <= !state_cmd_emulate_in && (state_cmd_value_in[3:2] == PS_NAP[3:2]);
        end else if (tx_done) begin
            dormant_pend_ff <= 1'b0;
        end
    end

    // ****************************************
    // Previous-state handshake
    // ****************************************
    // Acknowledge rises with data valid, falls after the request falls.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prev_state_ack_out <= 1'b0;
        end else if (prev_state_req_in && !prev_state_ack_out) begin
            prev_state_ack_out <= 1'b1;
        end else if (prev_state_ack_out && !prev_state_req_in) begin
            prev_state_ack_out <= 1'b0;
        end
    end

    // Receive bus and flag follow the remembered state; stable under each acknowledge.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prev_state_value_out    <= PS_RESET_VALUE;
            prev_state_emulated_out <= 1'b0;
        end else if (!prev_state_ack_out) begin
            prev_state_value_out    <= tx_take ? state_cmd_value_in : cur_state_ff;
            prev_state_emulated_out <= tx_take ? state_cmd_emulate_in : cur_emul_ff;
        end
    end

    // ****************************************
    // Reset and power sequencer
    // ****************************************
    // Walks hard reset, soft stretch, run, power-off and emulated soft reset.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rst_state_ff <= RS_HARD;
            cnt_ff       <= CNT_ZERO;
        end else begin
            unique case (rst_state_ff)
                RS_HARD: begin
                    cnt_ff <= cnt_end ? CNT_ZERO : cnt_ff + 4'h1;
                    if (cnt_end) begin
                        rst_state_ff <= RS_SOFT;
                    end
                end
                RS_SOFT: begin
                    cnt_ff <= cnt_end ? CNT_ZERO : cnt_ff + 4'h1;
                    if (cnt_end) begin
                        rst_state_ff <= RS_RUN;
                    end
                end
                RS_RUN: begin
                    cnt_ff <= CNT_ZERO;
                    if (tx_done && dormant_pend_ff) begin
                        rst_state_ff <= RS_OFFV;
                    end else if (tx_done && cur_emul_ff) begin
                        rst_state_ff <= RS_EMUL;
                    end
                end
                RS_OFFV: begin
                    cnt_ff <= CNT_ZERO;
                    if (power_restore_in) begin
                        rst_state_ff <= RS_SOFT;
                    end
                end
                RS_EMUL: begin
                    cnt_ff <= cnt_end ? CNT_ZERO : cnt_ff + 4'h1;
                    if (cnt_end) begin
                        rst_state_ff <= RS_RUN;
                    end
                end
                default: begin
                    rst_state_ff <= RS_HARD;
                    cnt_ff       <= CNT_ZERO;
                end
            endcase
        end
    end

    // Reset pins are registered copies of the sequencer's next view.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            hard_reset_n_out <= 1'b0;
            soft_reset_n_out <= 1'b0;
        end else begin
            hard_reset_n_out <= !(rst_state_ff == RS_HARD && !cnt_end);
            soft_reset_n_out <= (rst_state_ff == RS_RUN && !(tx_done && (dormant_pend_ff || cur_emul_ff)))
                                || (rst_state_ff != RS_RUN && rst_state_ff != RS_OFFV && cnt_end
                                    && rst_state_ff != RS_HARD);
        end
    end

    // Regulators: core power and cache retention change only on real power-down and on the restore after it.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            core_power_on_out <= 1'b1;
            cache_retain_out  <= 1'b0;
        end else if (rst_state_ff == RS_RUN && tx_done && dormant_pend_ff) begin
            core_power_on_out <= 1'b0;
            cache_retain_out  <= 1'b1;
        end else if (rst_state_ff == RS_OFFV && power_restore_in) begin
            core_power_on_out <= 1'b1;
            cache_retain_out  <= 1'b0;
        end
    end

    // ****************************************
    // Checks: reset sequencing
    // ****************************************
    // Both reset pins are low in any cycle where hard reset is low.
    sequence s_hard_start;
        !hard_reset_n_out && !soft_reset_n_out;
    endsequence

    // Hard reset is low for eight cycles after reset leaves, then rises.
    chk_hard_reset_len: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(srst_in) |-> !hard_reset_n_out [*8] ##1 hard_reset_n_out)
        else $error("hard reset not held for eight cycles");

    // Soft reset is never high while hard reset is low.
    chk_resets_same_cycle: assert property (@(posedge clk_in) disable iff (srst_in)
        !hard_reset_n_out |-> s_hard_start)
        else $error("hard and soft reset not asserted together");

    // Soft reset stays low for eight cycles after hard reset rises.
    chk_soft_after_hard: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(hard_reset_n_out) |-> !soft_reset_n_out [*8])
        else $error("soft reset released too early after hard reset");

    // Soft reset is only ever released into the running state.
    chk_soft_release_run: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(soft_reset_n_out) |-> running)
        else $error("soft reset released outside the running state");

    // Presence stays high once reset has been seen.
    chk_present_high: assert property (@(posedge clk_in) disable iff (srst_in)
        manager_present_out)
        else $error("presence signal low");

    // ****************************************
    // Checks: command handshake
    // ****************************************
    // The entered state shows on the receive bus with the acknowledge.
    chk_tx_ack_data: assert property (@(posedge clk_in) disable iff (srst_in)
        (tx_take && !prev_state_ack_out) |=> state_cmd_ack_out && (prev_state_value_out == $past(state_cmd_value_in)))
        else $error("entered state not reported with acknowledge");

    // The emulation flag of the entered state travels with it.
    chk_tx_ack_flag: assert property (@(posedge clk_in) disable iff (srst_in)
        (tx_take && !prev_state_ack_out) |=> prev_state_emulated_out == $past(state_cmd_emulate_in))
        else $error("entered state flag not reported with acknowledge");

    // The acknowledge holds while the request holds and falls after it.
    chk_tx_ack_phase: assert property (@(posedge clk_in) disable iff (srst_in)
        state_cmd_ack_out |=> state_cmd_ack_out == $past(state_cmd_req_in))
        else $error("command acknowledge broke the four-phase order");

    // No command is acknowledged outside the running state.
    chk_tx_refused: assert property (@(posedge clk_in) disable iff (srst_in)
        (!running && !state_cmd_ack_out) |=> !state_cmd_ack_out)
        else $error("command acknowledged while not running");

    // An emulated command never arms the power-down.
    chk_emul_no_dormant: assert property (@(posedge clk_in) disable iff (srst_in)
        (tx_take && state_cmd_emulate_in) |=> !dormant_pend_ff)
        else $error("emulated command armed power-down");

    // ****************************************
    // Checks: previous-state handshake
    // ****************************************
    // A fresh previous-state request is acknowledged in the next cycle.
    chk_rx_ack_rise: assert property (@(posedge clk_in) disable iff (srst_in)
        (prev_state_req_in && !prev_state_ack_out) |=> prev_state_ack_out)
        else $error("previous-state request not acknowledged");

    // The acknowledge follows the request down, four-phase.
    chk_rx_ack_phase: assert property (@(posedge clk_in) disable iff (srst_in)
        prev_state_ack_out |=> prev_state_ack_out == $past(prev_state_req_in))
        else $error("previous-state acknowledge broke the four-phase order");

    // Receive data stays still under a standing acknowledge.
    chk_rx_ack_stable: assert property (@(posedge clk_in) disable iff (srst_in)
        (prev_state_ack_out && $past(prev_state_ack_out)) |-> $stable(prev_state_value_out))
        else $error("receive data changed under acknowledge");

    // The emulation flag stays still under a standing acknowledge.
    chk_rx_flag_stable: assert property (@(posedge clk_in) disable iff (srst_in)
        (prev_state_ack_out && $past(prev_state_ack_out)) |-> $stable(prev_state_emulated_out))
        else $error("receive flag changed under acknowledge");

    // ****************************************
    // Checks: power and emulation
    // ****************************************
    // A dormant command finishes its handshake.
    sequence s_dormant_done;
        running && tx_done && dormant_pend_ff;
    endsequence
    // An emulated command finishes its handshake.
    sequence s_emul_done;
        running && tx_done && cur_emul_ff && !dormant_pend_ff;
    endsequence

    // Power is removed only right after an acknowledged command.
    chk_power_after_ack: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(core_power_on_out) |-> $past(state_cmd_ack_out) && cache_retain_out)
        else $error("power removed without acknowledged dormant entry");

    // A finished dormant command drops power, keeps cache and holds soft reset.
    chk_dormant_down: assert property (@(posedge clk_in) disable iff (srst_in)
        s_dormant_done |=> !core_power_on_out && cache_retain_out && !soft_reset_n_out)
        else $error("dormant entry did not power down");

    // Soft reset is held low all the time the core is unpowered.
    chk_soft_while_off: assert property (@(posedge clk_in) disable iff (srst_in)
        !core_power_on_out |-> !soft_reset_n_out)
        else $error("soft reset released while core power off");

    // Cache retention is only used while the core is unpowered.
    chk_retain_only_off: assert property (@(posedge clk_in) disable iff (srst_in)
        cache_retain_out |-> !core_power_on_out)
        else $error("cache retention while core powered");

    // Soft reset stays low for eight cycles after power returns.
    chk_soft_after_power: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(core_power_on_out) |-> !soft_reset_n_out [*8])
        else $error("soft reset released too early after power return");

    // Power comes back only on a restore, with the cache raised too.
    chk_power_return: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(core_power_on_out) |-> $past(power_restore_in) && !cache_retain_out)
        else $error("power returned without restore");

    // A finished emulated command leaves both regulator controls alone.
    chk_emul_keeps_power: assert property (@(posedge clk_in) disable iff (srst_in)
        s_emul_done |=> $stable(core_power_on_out) && $stable(cache_retain_out))
        else $error("emulated command changed regulators");

    // A finished emulated command is followed by an eight-cycle soft reset.
    chk_emul_soft_reset: assert property (@(posedge clk_in) disable iff (srst_in)
        s_emul_done |=> !soft_reset_n_out [*8])
        else $error("no soft reset sequence after emulated command");
endmodule : pmh_manager

//--- rtl/pmh_pkg.sv
// Purpose : Constants shared by the power manager handshake port.
// Assumes : One 100 MHz clock, synchronous active-high reset.
// Notes   : Power-state codes and reset stretch counts live here.
package pmh_pkg;
    localparam int unsigned STATE_W         = 4;
    // Power-state codes.
    localparam logic [3:0]  PS_TURBO        = 4'hf;
    localparam logic [3:0]  PS_NORMAL       = 4'he;
    localparam logic [3:0]  PS_SLOW         = 4'hc;
    localparam logic [3:0]  PS_IDLE         = 4'h8;
    localparam logic [3:0]  PS_NAP          = 4'h4;
    localparam logic [3:0]  PS_SLEEP        = 4'h3;
    localparam logic [3:0]  PS_COMA         = 4'h2;
    localparam logic [3:0]  PS_HIBERNATE    = 4'h1;
    localparam logic [3:0]  PS_OFF          = 4'h0;
    localparam logic [3:0]  PS_RESET_VALUE  = PS_OFF;
    // Reset stretch, in clock cycles.
    localparam int unsigned RST_CYCLES      = 8;
    localparam int unsigned CNT_W           = 4;
    localparam logic [3:0]  CNT_LAST        = 4'(RST_CYCLES - 1);
    localparam logic [3:0]  CNT_ZERO        = 4'h0;
    // Reset sequencer states.
    typedef enum logic [2:0] {
        RS_HARD  = 3'b000,
        RS_SOFT  = 3'b001,
        RS_RUN   = 3'b010,
        RS_OFFV  = 3'b011,
        RS_EMUL  = 3'b100
    } pmh_rst_state_t;
endpackage : pmh_pkg

//--- testbench/pmh_cpu_model.sv
// Purpose : Processor side of the power manager handshake port.
// Assumes : Requests change 1 ns after a rising edge; acks are registered.
// Notes   : Released command lines show the inverse of the last value.
`timescale 1ns/1ps
module pmh_cpu_model (
    input  wire logic                        clk_in,
    input  wire logic                        state_cmd_ack_in,
    input  wire logic                        prev_state_ack_in,
    input  wire logic [pmh_pkg::STATE_W-1:0] prev_state_value_in,
    input  wire logic                        prev_state_emulated_in,
    output logic                             state_cmd_req_out,
    output logic [pmh_pkg::STATE_W-1:0]      state_cmd_value_out,
    output logic                             state_cmd_emulate_out,
    output logic                             prev_state_req_out
);
    import pmh_pkg::*;
    // Both requests start idle.
    initial begin
        state_cmd_req_out     = 1'b0;
        state_cmd_value_out   = 4'h0;
        state_cmd_emulate_out = 1'b0;
        prev_state_req_out    = 1'b0;
    end
    // One four-phase handshake; hold stretches the request past the ack.
    task automatic shake(input logic cmd, input logic [3:0] val, input logic emu, input int hold,
                         output logic ok, output logic [3:0] rx, output logic rx_emu);
        int n;
        ok = 1'b1;
        n  = 0;
        @(posedge clk_in);
        #1;
        if (cmd) begin
            state_cmd_value_out   = val;
            state_cmd_emulate_out = emu;
            state_cmd_req_out     = 1'b1;
        end else begin
            prev_state_req_out = 1'b1;
        end
        do begin
            @(posedge clk_in);
            n++;
        end while ((cmd ? state_cmd_ack_in : prev_state_ack_in) !== 1'b1 && n < 50);
        if (n >= 50) ok = 1'b0;
        rx     = prev_state_value_in;
        rx_emu = prev_state_emulated_in;
        // The ack must stand while the request is still held.
        repeat (hold) begin
            @(posedge clk_in);
            if ((cmd ? state_cmd_ack_in : prev_state_ack_in) !== 1'b1) ok = 1'b0;
        end
        #1;
        state_cmd_req_out     = 1'b0;
        prev_state_req_out    = 1'b0;
        state_cmd_value_out   = ~state_cmd_value_out;
        state_cmd_emulate_out = ~state_cmd_emulate_out;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while ((cmd ? state_cmd_ack_in : prev_state_ack_in) !== 1'b0 && n < 50);
        if (n >= 50) ok = 1'b0;
    endtask : shake
endmodule : pmh_cpu_model

//--- testbench/test_power_manager_handshake_port.sv
// Purpose : Self-checking bench for the power manager end.
// Assumes : 100 MHz clock, reset held 8 cycles, inputs moved 1 ns after edges, power_restore_in 3 ns after edges.
// Notes   : Dormant entry is a plain nap command; restore is driven here.
`timescale 1ns/1ps
module test_power_manager_handshake_port;
    import pmh_pkg::*;
    logic       clk_in = 1'b0, srst_in = 1'b1, power_restore_in = 1'b0;
    logic       req_c, emu_c, req_p, present, ack_c, ack_p, emu_rx, hard_n, soft_n, core_on, retain;
    logic [3:0] val_c, val_rx, last_rx;
    logic       last_emu, ok;
    int         num_errors = 0, total_checks = 0;
    logic [3:0] codes [8] = '{PS_TURBO, PS_NORMAL, PS_SLOW, PS_IDLE, PS_SLEEP, PS_COMA, PS_HIBERNATE, PS_OFF};
    // Free-running 100 MHz clock.
    always #5 clk_in = ~clk_in;
    pmh_manager pmh_manager_inst (.clk_in(clk_in), .srst_in(srst_in), .state_cmd_req_in(req_c),
        .state_cmd_value_in(val_c), .state_cmd_emulate_in(emu_c), .prev_state_req_in(req_p),
        .power_restore_in(power_restore_in), .manager_present_out(present), .state_cmd_ack_out(ack_c),
        .prev_state_ack_out(ack_p), .prev_state_value_out(val_rx), .prev_state_emulated_out(emu_rx),
        .hard_reset_n_out(hard_n), .soft_reset_n_out(soft_n), .core_power_on_out(core_on),
        .cache_retain_out(retain));
    pmh_cpu_model pmh_cpu_model_inst (.clk_in(clk_in), .state_cmd_ack_in(ack_c), .prev_state_ack_in(ack_p),
        .prev_state_value_in(val_rx), .prev_state_emulated_in(emu_rx), .state_cmd_req_out(req_c),
        .state_cmd_value_out(val_c), .state_cmd_emulate_out(emu_c), .prev_state_req_out(req_p));
    // ***********************************************
    // Compare and report tasks
    // ***********************************************
    task automatic check_bit(input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check_bit
    task automatic check_val(input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check_val
    task automatic results();
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    // One handshake; a hang ends the run as a failure.
    task automatic run(input logic cmd, input logic [3:0] v, input logic e, input int hold, input logic [3:0] exp);
        pmh_cpu_model_inst.shake(cmd, v, e, hold, ok, last_rx, last_emu);
        if (ok !== 1'b1) begin
            num_errors++;
            results();
        end
        check_val(exp, last_rx);
    endtask : run
    // Soft reset stays low for six samples and is released at the seventh edge.
    task automatic soft_release();
        repeat (6) begin
            @(posedge clk_in);
            #2;
            check_bit(1'b0, soft_n);
        end
        @(posedge clk_in);
        #2;
        check_bit(1'b1, soft_n);
    endtask : soft_release
    // ***********************************************
    // Scenarios
    // ***********************************************
    task automatic t_reset();
        #1 srst_in = 1'b0;
        check_bit(1'b0, hard_n);
        check_bit(1'b0, soft_n);
        check_bit(1'b1, present);
        for (int k = 1; k <= 16; k++) begin
            @(posedge clk_in);
            #2;
            check_bit(k >= 8, hard_n);
            check_bit(k >= 16, soft_n);
        end
    endtask : t_reset
    task automatic t_codes();
        foreach (codes[i]) begin
            run(1'b1, codes[i], 1'b0, i % 3, codes[i]);
            check_bit(1'b1, core_on);
            run(1'b0, 4'h0, 1'b0, 1, codes[i]);
            check_bit(1'b0, last_emu);
        end
    endtask : t_codes
    task automatic t_emul();
        run(1'b1, 4'h5, 1'b1, 0, 4'h5);
        check_bit(1'b1, core_on);
        check_bit(1'b0, retain);
        soft_release();
        run(1'b0, 4'h0, 1'b0, 0, 4'h5);
        check_bit(1'b1, last_emu);
    endtask : t_emul
    task automatic t_dormant();
        int n;
        run(1'b1, PS_NAP, 1'b0, 0, PS_NAP);
        repeat (20) begin
            @(posedge clk_in);
            #2;
            check_bit(1'b0, core_on);
            check_bit(1'b1, retain);
            check_bit(1'b0, soft_n);
        end
        #1 power_restore_in = 1'b1;
        for (n = 0; n < 20 && core_on !== 1'b1; n++) @(posedge clk_in);
        check_bit(1'b1, core_on);
        check_bit(1'b0, retain);
        soft_release();
        #1 power_restore_in = 1'b0;
        run(1'b1, PS_NORMAL, 1'b0, 2, PS_NORMAL);
    endtask : t_dormant
    // Main sequence: reset for 8 cycles, then each scenario in turn.
    initial begin
        repeat (8) @(posedge clk_in);
        t_reset();
        t_codes();
        t_emul();
        t_dormant();
        results();
    end
endmodule : test_power_manager_handshake_port
